//--- rtl/cal_link_defs.vh
/*
  Constants for the calibration command link: command bytes, response
  layout, timing and pulse constant limits.
  Assumes inclusion by name from the link modules; definitions only.
*/
// Contract
// - Command byte EF starts dc offset calibration of every voltage and current channel.
// - After 32 calibration cycles the offsets are published and FE is sent as the done marker.
// - Request byte 45 returns the full measurement and coefficient table with new offsets.
// - Fundamental current phase angles sit at stream bytes 283, 371 and 459 for the three phases; the stream here ends at byte 401, so 459 is never sent.
// - Harmonic data covers magnitude and phase of odd harmonics from fundamental to 21st.
// - Two energy pulse outputs, one active or apparent, one reactive, 1000 to 20000 per kWh.
// - Four-byte values go least significant word first; the host swaps the words.
`ifndef CAL_LINK_DEFS_VH
`define CAL_LINK_DEFS_VH

`define CMD_OFFSET_CAL 8'hEF
`define CMD_TABLE 8'h45
`define MARK_CAL_DONE 8'hFE
`define CAL_CYCLES 6'd32
`define UNITY_GAIN 16'h4000
// Response layout, byte index from the request echo at 0
`define POS_PHASE_A 10'd283
`define POS_PHASE_B 10'd371
`define POS_PHASE_C 10'd459
`define POS_GAIN 10'd99
`define POS_OFFSET 10'd117
`define POS_DONE 10'd135
`define POS_HARM 10'd138
`define TABLE_LEN 10'd402
`define HARM_WORDS 11
`define PULSE_MIN 16'd1000
`define PULSE_MAX 16'd20000
`define PULSE_DEF 16'd1000

`endif

//--- rtl/spi_byte_port.v
/*
  SPI slave byte shifter, mode 0, MSB first.
  Assumes sclk, csN and mosi are synchronous to core_clk and slow
  against it; edges are found by comparing with a delayed copy.
*/
`timescale 1ns/1ps
module spi_byte_port
(
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // Pins
  input wire sclk,
  input wire csN,
  input wire mosi,
  output reg miso,
  // Byte side
  input wire [7:0] txByte,
  output reg [7:0] rxByte,
  output reg rxValid
);

  reg sclkDly_q;
  reg [2:0] bitCnt_q;
  reg [7:0] shiftIn_q;
  reg [7:0] shiftOut_q;
  wire rise;
  wire fall;

  assign rise = sclk & ~sclkDly_q & ~csN;
  assign fall = ~sclk & sclkDly_q & ~csN;

  // Whole-byte transfers only; a partial byte dies with csN
  always @(posedge core_clk)
  begin
    rxValid <= 1'b0;
    if (!nrst)
    begin
      sclkDly_q <= 1'b0;
      bitCnt_q <= 3'd0;
      shiftIn_q <= 8'h00;
      shiftOut_q <= 8'h00;
      rxByte <= 8'h00;
      miso <= 1'b0;
    end
    else
    begin
      sclkDly_q <= sclk;
      if (csN)
      begin
        bitCnt_q <= 3'd0;
        shiftOut_q <= txByte;
        miso <= txByte[7];
      end
      else if (rise)
      begin
        shiftIn_q <= {shiftIn_q[6:0], mosi};
        bitCnt_q <= bitCnt_q + 3'd1;
        if (bitCnt_q == 3'd7)
        begin
          rxByte <= {shiftIn_q[6:0], mosi};
          rxValid <= 1'b1;
        end
      end
      else if (fall)
      begin
        if (bitCnt_q == 3'd0)
        begin
          // Byte boundary: load the next byte to send
          shiftOut_q <= txByte;
          miso <= txByte[7];
        end
        else
        begin
          shiftOut_q <= {shiftOut_q[6:0], 1'b0};
          miso <= shiftOut_q[6];
        end
      end
    end
  end

endmodule

//--- rtl/meter_cal_link.v
/*
  Calibration command link of the metering processor: decodes SPI
  command bytes, runs dc offset calibration, streams the measurement
  and coefficient table, takes the init load and drives energy pulses.
  Assumes SPI pins synchronous to core_clk, measurement values supplied
  as flat ports, and a one-cycle energy quantum strobe each for active, apparent and reactive energy.
*/
`timescale 1ns/1ps
`include "cal_link_defs.vh"
module meter_cal_link
#(
  parameter CH = 6,
  parameter INIT_BYTES = 120
)
(
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // SPI pins
  input wire sclk,
  input wire csN,
  input wire mosi,
  output reg miso,
  // Measurement front end
  input wire sampleStrobe,
  input wire [CH*16-1:0] sampleData,
  input wire [8*`TABLE_LEN-1:0] measBlob,
  input wire [6*`HARM_WORDS*16-1:0] harmPhase,
  input wire activeQuantum,
  input wire apparentQuantum,
  input wire reactiveQuantum,
  input wire pulseSelApparent,
  // Outputs
  output reg [CH*16-1:0] dcOffset,
  output reg [16*CH-1:0] gainCoef,
  output reg calBusy,
  output reg initDone,
  output reg energyPulse1,
  output reg energyPulse2
);

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam ST_IDLE = 4'b0001;
  localparam ST_CAL = 4'b0010;
  localparam ST_STREAM = 4'b0100;
  localparam ST_LOAD = 4'b1000;

  reg [3:0] state_q;
  reg [5:0] calCnt_q;
  reg [9:0] bytePos_q;
  reg [CH*22-1:0] acc_q;
  reg [7:0] txByte_q;
  reg [15:0] pulseConst_q;
  reg [15:0] loadWord_q;
  reg [15:0] cnt1_q;
  reg [15:0] cnt2_q;
  reg [7:0] loadLo_q;
  reg [7:0] pendDone_q;
  reg donePend_q;
  wire [7:0] rxByte;
  wire rxValid;
  wire misoInt;
  integer i;

  // Byte of the response stream at a position
  function [7:0] streamByte;
    input [9:0] pos;
    input [8*`TABLE_LEN-1:0] blob;
    input [16*CH-1:0] gains;
    input [CH*16-1:0] offs;
    reg [9:0] k;
    begin
      k = 10'd0;
      streamByte = blob[pos*8 +: 8];
      if (pos == 10'd0)
        streamByte = `CMD_TABLE;
      else if (pos >= `POS_GAIN && pos < `POS_GAIN + 10'd12)
      begin
        k = pos - `POS_GAIN;
        // Low byte first within each 16-bit word
        streamByte = gains[k*8 +: 8];
      end
      else if (pos >= `POS_OFFSET && pos < `POS_OFFSET + 10'd12)
      begin
        k = pos - `POS_OFFSET;
        streamByte = offs[k*8 +: 8]; // Fresh offsets in the table
      end
      else if (pos == `POS_DONE)
        streamByte = `CMD_OFFSET_CAL;
    end
  endfunction

  // Accumulators plus one sample per channel, sign extended
  function [CH*22-1:0] addSample;
    input [CH*22-1:0] a;
    input [CH*16-1:0] d;
    integer j;
    begin
      addSample = a;
      for (j = 0; j < CH; j = j + 1)
        addSample[j*22 +: 22] = a[j*22 +: 22] + {{6{d[j*16+15]}}, d[j*16 +: 16]};
    end
  endfunction

  wire [CH*22-1:0] accSum;

  // Shared by the running sum and the final average
  assign accSum = addSample(acc_q, sampleData);

  // Harmonic phase byte; fundamental lands on fixed positions
  function [7:0] harmByte;
    input [9:0] pos;
    input [6*`HARM_WORDS*16-1:0] h;
    reg [9:0] k;
    begin
      k = pos - `POS_HARM;
      harmByte = h[k*8 +: 8];
    end
  endfunction

  // ---------------------------------------------------------------
  // SPI shifter
  // ---------------------------------------------------------------
  spi_byte_port u_spi
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .sclk(sclk),
    .csN(csN),
    .mosi(mosi),
    .miso(misoInt),
    .txByte(txByte_q),
    .rxByte(rxByte),
    .rxValid(rxValid)
  );

  // Output pin flop keeps every top output registered
  always @(posedge core_clk)
  begin
    if (!nrst)
      miso <= 1'b0;
    else
      miso <= misoInt;
  end

  // ---------------------------------------------------------------
  // Command interpreter
  // ---------------------------------------------------------------
  // Offsets are averaged over 32 cycles, so no divider is needed
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
      calCnt_q <= 6'd0;
      bytePos_q <= 10'd0;
      acc_q <= {CH*22{1'b0}};
      txByte_q <= 8'h00;
      dcOffset <= {CH*16{1'b0}};
      gainCoef <= {CH{`UNITY_GAIN}};
      calBusy <= 1'b0;
      initDone <= 1'b0;
      pulseConst_q <= `PULSE_DEF;
      loadLo_q <= 8'h00;
      loadWord_q <= 16'h0000;
      donePend_q <= 1'b0;
      pendDone_q <= 8'h00;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          txByte_q <= donePend_q ? `MARK_CAL_DONE : 8'h00;
          if (rxValid && donePend_q)
            donePend_q <= 1'b0; // Marker went out with this byte
          if (rxValid && rxByte == `CMD_OFFSET_CAL)
          begin
            state_q <= ST_CAL;
            calCnt_q <= 6'd0;
            acc_q <= {CH*22{1'b0}};
            calBusy <= 1'b1;
          end
          else if (rxValid && rxByte == `CMD_TABLE && !initDone)
          begin
            state_q <= ST_LOAD; // Power-up load follows 45
            bytePos_q <= 10'd0;
          end
          else if (rxValid && rxByte == `CMD_TABLE)
          begin
            state_q <= ST_STREAM;
            bytePos_q <= 10'd1;
            txByte_q <= streamByte(10'd1, measBlob, gainCoef, dcOffset);
          end
        end
        ST_CAL:
        begin
          if (sampleStrobe)
          begin
            acc_q <= accSum;
            calCnt_q <= calCnt_q + 6'd1;
            if (calCnt_q == `CAL_CYCLES - 6'd1)
            begin
              // Average takes the last sample too, else only 31 count
              for (i = 0; i < CH; i = i + 1)
                dcOffset[i*16 +: 16] <= accSum[i*22+5 +: 16];
              state_q <= ST_IDLE;
              calBusy <= 1'b0;
              donePend_q <= 1'b1;
            end
          end
        end
        ST_STREAM:
        begin
          // Host raises select after every byte, so only the count ends it
          if (rxValid)
          begin
            bytePos_q <= bytePos_q + 10'd1; // Byte count from response start
            if (bytePos_q + 10'd1 >= `TABLE_LEN)
              state_q <= ST_IDLE;
            else if (bytePos_q + 10'd1 >= `POS_HARM && bytePos_q + 10'd1 < `POS_HARM + 10'd132)
              txByte_q <= harmByte(bytePos_q + 10'd1, harmPhase);
            else
              txByte_q <= streamByte(bytePos_q + 10'd1, measBlob, gainCoef, dcOffset);
          end
        end
        ST_LOAD:
        begin
          if (rxValid)
          begin
            bytePos_q <= bytePos_q + 10'd1;
            if (!bytePos_q[0])
              loadLo_q <= rxByte;
            else
            begin
              loadWord_q <= {rxByte, loadLo_q};
              // Word order: pulse constant, gains, offsets
              if (bytePos_q == 10'd1)
              begin
                // Out-of-range constants are clamped
                if ({rxByte, loadLo_q} < `PULSE_MIN)
                  pulseConst_q <= `PULSE_MIN;
                else if ({rxByte, loadLo_q} > `PULSE_MAX)
                  pulseConst_q <= `PULSE_MAX;
                else
                  pulseConst_q <= {rxByte, loadLo_q};
              end
              else if (bytePos_q < 10'd14)
                gainCoef[(bytePos_q[9:1]-10'd1)*16 +: 16] <= {rxByte, loadLo_q};
              else if (bytePos_q < 10'd26)
                dcOffset[(bytePos_q[9:1]-10'd7)*16 +: 16] <= {rxByte, loadLo_q};
            end
            if (bytePos_q == INIT_BYTES - 1)
            begin
              state_q <= ST_IDLE;
              initDone <= 1'b1;
            end
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Energy pulse outputs
  // ---------------------------------------------------------------
  // Counter reaches 20001 minus the constant per pulse; quanta scaled upstream
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cnt1_q <= 16'd0;
      cnt2_q <= 16'd0;
      energyPulse1 <= 1'b0;
      energyPulse2 <= 1'b0;
    end
    else
    begin
      energyPulse1 <= 1'b0;
      energyPulse2 <= 1'b0;
      if (pulseSelApparent ? apparentQuantum : activeQuantum)
      begin
        if (cnt1_q + 16'd1 >= `PULSE_MAX + 16'd1 - pulseConst_q)
        begin
          cnt1_q <= 16'd0;
          energyPulse1 <= 1'b1;
        end
        else
          cnt1_q <= cnt1_q + 16'd1;
      end
      if (reactiveQuantum)
      begin
        if (cnt2_q + 16'd1 >= `PULSE_MAX + 16'd1 - pulseConst_q)
        begin
          cnt2_q <= 16'd0;
          energyPulse2 <= 1'b1;
        end
        else
          cnt2_q <= cnt2_q + 16'd1;
      end
    end
  end

endmodule

//--- dv/meter_cal_link_checker.sv
/*
  Checker for the calibration link: SPI framing, calibration flags, miso timing.
  Assumes SPI pins synchronous to core_clk; bound to every link instance.
*/
`timescale 1ns/1ps
`include "cal_link_defs.vh"
module meter_cal_link_checker
#(
  parameter CH = 6
)
(
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // Pins and flags
  input wire sclk,
  input wire csN,
  input wire mosi,
  input wire miso,
  input wire sampleStrobe,
  input wire [CH*16-1:0] dcOffset,
  input wire [16*CH-1:0] gainCoef,
  input wire calBusy,
  input wire initDone
);
  reg sclkD_q;
  reg [2:0] bit_q;
  reg [7:0] mo_q;
  reg [7:0] mi_q;
  reg [7:0] last_q;
  reg mark_q;
  reg [5:0] cnt_q;
  wire rise = sclk && !sclkD_q;
  wire done = rise && !csN && bit_q == 3'd7;
  wire [7:0] moB = {mo_q[6:0], mosi};
  wire [7:0] miB = {mi_q[6:0], miso};
  // Own framer, so a slip in the design's shifter is not shared
  always @(posedge core_clk)
    sclkD_q <= sclk;
  always @(posedge core_clk)
    if (!nrst || csN)
      bit_q <= 3'd0;
    else if (rise)
      bit_q <= bit_q + 3'd1;
  always @(posedge core_clk)
    if (rise)
      {mo_q, mi_q} <= {moB, miB};
  // Last received byte and pending done marker
  always @(posedge core_clk)
    if (!nrst)
      last_q <= 8'h00;
    else if (done)
      last_q <= moB;
  always @(posedge core_clk)
    if (!nrst)
      mark_q <= 1'b0;
    else if ($fell(calBusy))
      mark_q <= 1'b1;
    else if (done)
      mark_q <= 1'b0;
  // Strobes seen while busy
  always @(posedge core_clk)
    if (!nrst || !calBusy)
      cnt_q <= 6'd0;
    else if (sampleStrobe)
      cnt_q <= cnt_q + 6'd1;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  chk_gain_reset: assert property (nrst && !$past(nrst)
    |-> gainCoef == {CH{`UNITY_GAIN}} && !calBusy) else $error("gain not unity after reset");
  chk_busy_cause: assert property ($rose(calBusy) |-> last_q == `CMD_OFFSET_CAL)
    else $error("calibration started without command");
  chk_busy_start: assert property (done && moB == `CMD_OFFSET_CAL && initDone
    && !calBusy |-> ##[1:3] calBusy) else $error("command did not start calibration");
  chk_busy_hold: assert property (calBusy && !(cnt_q == 6'd31 && sampleStrobe)
    |=> calBusy) else $error("calibration ended early");
  chk_busy_end: assert property (calBusy && cnt_q == 6'd31 && sampleStrobe
    |-> ##[1:2] !calBusy) else $error("calibration overran");
  chk_offset_time: assert property ($changed(dcOffset) && $past(calBusy)
    |-> ##[0:1] !calBusy) else $error("offset changed mid calibration");
  chk_done_mark: assert property (done && mark_q |-> miB == `MARK_CAL_DONE)
    else $error("done marker missing");
  chk_miso_still: assert property (sclk && $past(sclk) |-> $stable(miso))
    else $error("miso moved while clock high");
endmodule
bind meter_cal_link meter_cal_link_checker #(.CH(CH)) i_meter_cal_link_checker (
  .core_clk(core_clk), .nrst(nrst), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
  .sampleStrobe(sampleStrobe), .dcOffset(dcOffset), .gainCoef(gainCoef),
  .calBusy(calBusy), .initDone(initDone));

//--- dv/spi_host_model.sv
/*
  SPI host model: mode 0, MSB first, one chip-select frame per byte.
  Assumes the device samples its pins on core_clk.
*/
`timescale 1ns/1ps
module spi_host_model
(
  // Clock
  input wire core_clk,
  // SPI pins
  output reg sclk,
  output reg csN,
  output reg mosi,
  input wire miso
);
  // Idle: clock still, deselected
  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b1;
  end
  // Whole byte per frame, three clocks per phase to respect the slow-edge limit
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      @(posedge core_clk);
      #1 csN = 1'b0;
      for (i = 7; i >= 0; i = i - 1)
      begin
        mosi = tx[i];
        repeat (3) @(posedge core_clk);
        #1 sclk = 1'b1;
        rx[i] = miso;
        repeat (3) @(posedge core_clk);
        #1 sclk = 1'b0;
      end
      repeat (3) @(posedge core_clk);
      #1 csN = 1'b1;
      mosi = ~mosi; // Released line shows no stale bit
    end
  endtask
endmodule

//--- dv/tb_meter_cal_link.sv
/*
  Testbench for the calibration link: init load, offset calibration,
  table stream and energy pulses, twice with a reset between.
  Assumes the SPI host model and the bound checker.
*/
`timescale 1ns/1ps
`include "cal_link_defs.vh"
module tb_meter_cal_link;
  localparam CH = 6;
  reg core_clk = 1'b0;
  reg nrst = 1'b0;
  reg sampleStrobe = 1'b0;
  reg [CH*16-1:0] sampleData = 0;
  reg [8*`TABLE_LEN-1:0] measBlob = 0;
  reg [6*`HARM_WORDS*16-1:0] harmPhase = 0;
  reg activeQuantum = 1'b0;
  reg apparentQuantum = 1'b0;
  reg reactiveQuantum = 1'b0;
  reg pulseSelApparent = 1'b0;
  wire sclk, csN, mosi, miso, calBusy, initDone, energyPulse1, energyPulse2;
  wire [CH*16-1:0] dcOffset;
  wire [16*CH-1:0] gainCoef;
  integer seed = 70933;
  integer mismatches = 0;
  integer samples_checked = 0;
  integer k, i, c, p1, p2;
  reg [7:0] rx;
  reg [7:0] resp [0:`TABLE_LEN-1];
  reg [15:0] gain [0:CH-1];
  reg [15:0] off [0:CH-1];
  reg [20:0] sum [0:CH-1];
  reg [15:0] pc;
  always #25 core_clk = ~core_clk;
  meter_cal_link #(.CH(CH), .INIT_BYTES(26)) i_meter_cal_link (.core_clk(core_clk),
    .nrst(nrst), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
    .sampleStrobe(sampleStrobe), .sampleData(sampleData), .measBlob(measBlob),
    .harmPhase(harmPhase), .activeQuantum(activeQuantum), .apparentQuantum(apparentQuantum),
    .reactiveQuantum(reactiveQuantum), .pulseSelApparent(pulseSelApparent),
    .dcOffset(dcOffset), .gainCoef(gainCoef), .calBusy(calBusy), .initDone(initDone),
    .energyPulse1(energyPulse1), .energyPulse2(energyPulse2));
  spi_host_model i_spi_host_model (.core_clk(core_clk), .sclk(sclk), .csN(csN),
    .mosi(mosi), .miso(miso));
  // Pulse counters
  always @(posedge core_clk)
  begin
    p1 <= p1 + (energyPulse1 === 1'b1);
    p2 <= p2 + (energyPulse2 === 1'b1);
  end
  task check(input [15:0] seen, input [15:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // Host sends words low byte first
  task send16(input [15:0] v);
  begin
    i_spi_host_model.xfer(v[7:0], rx);
    i_spi_host_model.xfer(v[15:8], rx);
  end
  endtask
  // Positive samples only, so truncation and flooring agree
  task strobe;
  begin
    @(posedge core_clk);
    #1;
    for (c = 0; c < CH; c = c + 1)
    begin
      sampleData[16*c+:16] = $random(seed) & 16'h3FFF;
      sum[c] = sum[c] + sampleData[16*c+:16];
    end
    sampleStrobe = 1'b1;
    @(posedge core_clk);
    #1 sampleStrobe = 1'b0;
    repeat (2) @(posedge core_clk);
  end
  endtask
  function integer expPulses(input integer n, input integer cst);
    expPulses = n / (20001 - (cst > 20000 ? 20000 : cst));
  endfunction
  task summarize;
  begin
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  // Two power-ups: the second reloads everything and clamps the pulse constant
  initial
  begin
    for (k = 0; k < 2; k = k + 1)
    begin
      @(posedge core_clk);
      #1 nrst = 1'b0;
      pulseSelApparent = k;
      pc = k ? 16'd30000 : 16'd19990;
      for (i = 0; i < `TABLE_LEN; i = i + 1)
        measBlob[8*i+:8] = $random(seed);
      for (i = 0; i < 132; i = i + 1)
        harmPhase[8*i+:8] = $random(seed);
      for (c = 0; c < CH; c = c + 1)
        {gain[c], off[c], sum[c]} = {$random(seed), 21'd0};
      repeat (4) @(posedge core_clk);
      #1 nrst = 1'b1;
      i_spi_host_model.xfer(`CMD_TABLE, rx);
      send16(pc);
      for (c = 0; c < CH; c = c + 1)
        send16(gain[c]);
      for (c = 0; c < CH; c = c + 1)
        send16(off[c]);
      for (i = 0; i < 20 && initDone !== 1'b1; i = i + 1)
        @(posedge core_clk);
      check(initDone, 1'b1);
      for (c = 0; c < CH; c = c + 1)
      begin
        check(gainCoef[16*c+:16], gain[c]);
        check(dcOffset[16*c+:16], off[c]);
      end
      i_spi_host_model.xfer(`CMD_OFFSET_CAL, rx);
      for (i = 0; i < 20 && calBusy !== 1'b1; i = i + 1)
        @(posedge core_clk);
      check(calBusy, 1'b1);
      // A table request while busy must be dropped
      fork
        i_spi_host_model.xfer(`CMD_TABLE, rx);
        repeat (32) strobe;
      join
      for (i = 0; i < 20 && calBusy !== 1'b0; i = i + 1)
        @(posedge core_clk);
      check(calBusy, 1'b0);
      for (c = 0; c < CH; c = c + 1)
        check(dcOffset[16*c+:16], sum[c][20:5]);
      i_spi_host_model.xfer(8'h00, rx);
      check(rx, `MARK_CAL_DONE);
      // Host wait before the table request is shortened to keep the run brief
      repeat (50) @(posedge core_clk);
      i_spi_host_model.xfer(`CMD_TABLE, rx);
      for (i = 1; i < `TABLE_LEN; i = i + 1)
        i_spi_host_model.xfer(8'h00, resp[i]);
      for (i = 1; i < 99; i = i + 1)
        check(resp[i], measBlob[8*i+:8]);
      for (c = 0; c < CH; c = c + 1)
      begin
        check({resp[100+2*c], resp[99+2*c]}, gain[c]);
        check({resp[118+2*c], resp[117+2*c]}, sum[c][20:5]);
      end
      check(resp[135], `CMD_OFFSET_CAL);
      for (i = 0; i < 132; i = i + 1)
        check(resp[138+i], harmPhase[8*i+:8]);
      p1 = 0;
      p2 = 0;
      for (i = 0; i < 66; i = i + 1)
      begin
        @(posedge core_clk);
        #1 {activeQuantum, apparentQuantum, reactiveQuantum} = {i[0], 2'b11};
        @(posedge core_clk);
        #1 {activeQuantum, apparentQuantum, reactiveQuantum} = 3'b000;
      end
      repeat (4) @(posedge core_clk);
      check(p1, expPulses(k ? 66 : 33, pc));
      check(p2, expPulses(66, pc));
      $display("test power-up %0d done", k);
    end
    summarize;
  end
  // Watchdog at about twice the expected run
  initial
  begin
    repeat (100000) @(posedge core_clk);
    mismatches = mismatches + 1;
    summarize;
  end
endmodule
